// *** include/cts_regs.vh ***
// register map, field positions and reset values of the transmit scheduler
`ifndef CTS_REGS_VH
`define CTS_REGS_VH

// ==========================================================================
// register offsets
`define CTS_TXB0_CTRL      8'h30
`define CTS_TXB1_CTRL      8'h40
`define CTS_TXB2_CTRL      8'h50
`define CTS_PIN_CTRL       8'h0D
`define CTS_CTRL_CTRL      8'h0E
`define CTS_INT_ENABLE     8'h2B
`define CTS_INT_FLAG       8'h2C

// ==========================================================================
// transmit buffer layout
`define CTS_NUM_BUF        3
`define CTS_BUF_BYTES      14
`define CTS_MEM_DEPTH      39
`define CTS_LEN_BYTE       4'h5
`define CTS_LAST_BYTE      4'hD
`define CTS_MAX_DATA       4'h8

// ==========================================================================
// buffer control byte fields
`define CTS_CTL_ABORTED    6
`define CTS_CTL_LOST       5
`define CTS_CTL_TRANSMIT_ERROR_FLAG      4
`define CTS_CTL_REQ        3
`define CTS_CTL_PRIO_HI    1
`define CTS_CTL_PRIO_LO    0

// ==========================================================================
// controller control fields
`define CTS_CC_ABORT_ALL   4
`define CTS_CC_CONFIG      7
`define CTS_CC_RESET       8'h80

// ==========================================================================
// interrupt enable and flag fields
`define CTS_INT_DONE_LO    0
`define CTS_INT_MERR       3

// ==========================================================================
// pin control fields
`define CTS_PIN_MODE_LO    0
`define CTS_PIN_STATE_LO   3
`define CTS_PIN_RESET      3'h0

`endif

// *** design/cts_buf_mem.v ***
// transmit buffer storage, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.vh"

module cts_buf_mem (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       wr_en,
  input  wire [5:0] wr_addr,
  input  wire [7:0] wr_data,
  input  wire       ra_en,
  input  wire [5:0] ra_addr,
  output reg  [7:0] ra_data,
  input  wire       rb_en,
  input  wire [5:0] rb_addr,
  output reg  [7:0] rb_data
);

  reg [7:0] mem [0:`CTS_MEM_DEPTH-1];

  // ========================================================================
  // write port
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ========================================================================
  // read ports
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ra_data <= 8'h00;
      rb_data <= 8'h00;
    end else begin
      if (ra_en) begin
        ra_data <= mem[ra_addr];
      end
      if (rb_en) begin
        rb_data <= mem[rb_addr];
      end
    end
  end

endmodule // cts_buf_mem

`default_nettype wire

// *** design/cts_scheduler.v ***
// transmit buffers, priority scheduler, request pins and abort handling
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.vh"

module cts_scheduler (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output wire [7:0] reg_rdata,
  input  wire [2:0] request_pin_n,
  input  wire       bus_idle,
  output wire       eng_tx_valid,
  output reg  [1:0] eng_tx_buf,
  output reg  [3:0] eng_data_count,
  input  wire       eng_start,
  input  wire       eng_done,
  input  wire       eng_error,
  input  wire       eng_lost_arb,
  input  wire       eng_rd_en,
  input  wire [3:0] eng_rd_byte,
  output wire [7:0] eng_rd_data,
  output reg        irq
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_OFFER = 2'h1;
  localparam [1:0] ST_SEND  = 2'h2;
  localparam [1:0] NO_BUF   = 2'h3;

  // ========================================================================
  // helper functions
  function [1:0] buf_of;
    input [7:0] a;
    begin
      case (a[7:4])
        4'h3:    buf_of = 2'h0;
        4'h4:    buf_of = 2'h1;
        4'h5:    buf_of = 2'h2;
        default: buf_of = NO_BUF;
      endcase
    end
  endfunction

  // buffer i, byte k (1..13) -> memory word
  function [5:0] mem_addr;
    input [1:0] b;
    input [3:0] k;
    reg   [5:0] base;
    begin
      base = 6'h00;
      case (b)
        2'h1:    base = 6'h0D;
        2'h2:    base = 6'h1A;
        default: base = 6'h00;
      endcase
      mem_addr = base + {2'h0, k} - 6'h01;
    end
  endfunction

  // winner among eligible buffers: higher priority, ties to higher index
  function [1:0] pick_best;
    input [2:0] elig;
    input [5:0] prios;
    integer     i;
    reg   [1:0] best;
    reg   [1:0] bp;
    begin
      best = NO_BUF;
      bp   = 2'h0;
      for (i = 0; i < `CTS_NUM_BUF; i = i + 1) begin
        if (elig[i] && (best == NO_BUF || prios[2*i +: 2] >= bp)) begin
          best = i[1:0];
          bp   = prios[2*i +: 2];
        end
      end
      pick_best = best;
    end
  endfunction

  // ========================================================================
  // state
  reg  [2:0] req;
  reg  [2:0] begun;
  reg  [2:0] aborted;
  reg  [2:0] lost;
  reg  [2:0] transmit_error_flag;
  reg  [5:0] prio;
  reg [11:0] len_code;
  reg  [2:0] pin_mode;
  reg  [2:0] pin_prev;
  reg        abort_all;
  reg        config_mode;
  reg  [3:0] int_en;
  reg  [3:0] int_flag;
  reg  [1:0] state;
  reg  [7:0] rdata_q;
  reg        rd_mem_q;

  reg  [1:0] next_state;
  reg  [1:0] next_sel;
  reg  [2:0] next_req;
  reg  [2:0] next_begun;
  reg  [2:0] next_aborted;
  reg  [2:0] next_lost;
  reg  [2:0] next_transmit_error_flag;
  reg  [3:0] next_int_flag;
  reg  [7:0] next_rdata;

  wire [1:0] wr_buf  = buf_of(reg_addr);
  wire [3:0] wr_byte = reg_addr[3:0];
  wire       in_buf  = (wr_buf != NO_BUF);
  wire       buf_ctl = in_buf && (wr_byte == 4'h0);
  wire       buf_dat = in_buf && (wr_byte != 4'h0) && (wr_byte <= `CTS_LAST_BYTE);

  // ========================================================================
  // request sources
  wire [2:0] ctl_wr;
  wire [2:0] pin_fall;
  wire [2:0] set_req;
  wire [2:0] clr_host;
  wire [2:0] clr_abort;
  wire [2:0] eligible;
  wire [1:0] best;
  wire       mem_wr;

  genvar g;
  generate
    for (g = 0; g < `CTS_NUM_BUF; g = g + 1) begin : gen_req
      assign ctl_wr[g]    = reg_wr && buf_ctl && (wr_buf == g);
      assign pin_fall[g]  = pin_mode[g] && pin_prev[g] && !request_pin_n[g];
      assign set_req[g]   = (ctl_wr[g] && reg_wdata[`CTS_CTL_REQ]) || pin_fall[g];
      assign clr_host[g]  = ctl_wr[g] && !reg_wdata[`CTS_CTL_REQ] && !begun[g];
      assign clr_abort[g] = abort_all && req[g] && !begun[g];
      assign eligible[g]  = req[g] && (begun[g] || !abort_all);
    end
  endgenerate

  assign best   = pick_best(eligible, prio);
  assign mem_wr = reg_wr && buf_dat && !req[wr_buf];
  assign eng_tx_valid = (state == ST_OFFER) && (eng_tx_buf != NO_BUF);

  // ========================================================================
  // buffer storage
  wire [7:0] host_mem_data;

  cts_buf_mem u_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (mem_wr),
    .wr_addr  (mem_addr(wr_buf, wr_byte)),
    .wr_data  (reg_wdata),
    .ra_en    (reg_rd && buf_dat),
    .ra_addr  (mem_addr(wr_buf, wr_byte)),
    .ra_data  (host_mem_data),
    .rb_en    (eng_rd_en),
    .rb_addr  (mem_addr(eng_tx_buf, eng_rd_byte)),
    .rb_data  (eng_rd_data)
  );

  // ========================================================================
  // scheduler and per-buffer status
  always @* begin
    next_state    = state;
    next_sel      = eng_tx_buf;
    next_req      = (req & ~clr_host & ~clr_abort) | set_req;
    next_begun    = begun;
    next_aborted  = aborted | clr_abort;
    next_lost     = lost;
    next_transmit_error_flag    = transmit_error_flag;
    next_int_flag = int_flag;
    if (reg_wr && reg_addr == `CTS_INT_FLAG) begin
      next_int_flag = int_flag & reg_wdata[3:0];
    end
    case (state)
      ST_IDLE: begin
        if (bus_idle && best != NO_BUF) begin
          next_sel   = best;
          next_state = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (eng_start && eng_tx_buf != NO_BUF && eligible[eng_tx_buf]) begin
          next_begun[eng_tx_buf] = 1'b1;
          next_req[eng_tx_buf]   = 1'b1;
          next_state = ST_SEND;
        end else if (best == NO_BUF) begin
          next_sel   = NO_BUF;
          next_state = ST_IDLE;
        end else begin
          next_sel = best;
        end
      end
      ST_SEND: begin
        if (eng_done) begin
          next_req[eng_tx_buf]      = set_req[eng_tx_buf];
          next_begun[eng_tx_buf]    = 1'b0;
          next_int_flag[eng_tx_buf] = 1'b1;
          next_state = ST_IDLE;
        end else if (eng_error) begin
          next_transmit_error_flag[eng_tx_buf]        = 1'b1;
          next_int_flag[`CTS_INT_MERR] = 1'b1;
          next_state = ST_IDLE;
        end else if (eng_lost_arb) begin
          next_lost[eng_tx_buf] = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_sel   = NO_BUF;
      end
    endcase
    // a fresh request starts with clean status
    next_aborted = next_aborted & ~(set_req & ~req);
    next_lost    = next_lost & ~(set_req & ~req);
    next_transmit_error_flag   = next_transmit_error_flag & ~(set_req & ~req);
  end

  // ========================================================================
  // register read mux
  always @* begin
    next_rdata = 8'h00;
    if (buf_ctl) begin
      next_rdata[`CTS_CTL_ABORTED] = aborted[wr_buf];
      next_rdata[`CTS_CTL_LOST]    = lost[wr_buf];
      next_rdata[`CTS_CTL_TRANSMIT_ERROR_FLAG]   = transmit_error_flag[wr_buf];
      next_rdata[`CTS_CTL_REQ]     = req[wr_buf];
      next_rdata[`CTS_CTL_PRIO_HI:`CTS_CTL_PRIO_LO] = prio[2*wr_buf +: 2];
    end else begin
      case (reg_addr)
        `CTS_PIN_CTRL: begin
          next_rdata[`CTS_PIN_MODE_LO +: 3]  = pin_mode;
          next_rdata[`CTS_PIN_STATE_LO +: 3] = request_pin_n & ~pin_mode;
        end
        `CTS_CTRL_CTRL: begin
          next_rdata[`CTS_CC_ABORT_ALL] = abort_all;
          next_rdata[`CTS_CC_CONFIG]    = config_mode;
        end
        `CTS_INT_ENABLE: next_rdata[3:0] = int_en;
        `CTS_INT_FLAG:   next_rdata[3:0] = int_flag;
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  assign reg_rdata = rd_mem_q ? host_mem_data : rdata_q;

  // ========================================================================
  // registers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state       <= ST_IDLE;
      eng_tx_buf  <= NO_BUF;
      req         <= 3'h0;
      begun       <= 3'h0;
      aborted     <= 3'h0;
      lost        <= 3'h0;
      transmit_error_flag       <= 3'h0;
      prio        <= 6'h00;
      len_code    <= 12'h000;
      pin_mode    <= `CTS_PIN_RESET;
      pin_prev    <= 3'h7;
      abort_all   <= 1'b0;
      config_mode <= 1'b1;
      int_en      <= 4'h0;
      int_flag    <= 4'h0;
      irq         <= 1'b0;
      rdata_q     <= 8'h00;
      rd_mem_q    <= 1'b0;
      eng_data_count <= 4'h0;
    end else begin
      state    <= next_state;
      eng_tx_buf <= next_sel;
      req      <= next_req;
      begun    <= next_begun;
      aborted  <= next_aborted;
      lost     <= next_lost;
      transmit_error_flag    <= next_transmit_error_flag;
      int_flag <= next_int_flag;
      pin_prev <= request_pin_n;
      irq      <= |(next_int_flag & int_en);
      if (reg_rd) begin
        rdata_q  <= next_rdata;
        rd_mem_q <= buf_dat;
      end
      if (next_sel != NO_BUF) begin
        if (len_code[4*next_sel +: 4] > `CTS_MAX_DATA) begin
          eng_data_count <= `CTS_MAX_DATA;
        end else begin
          eng_data_count <= len_code[4*next_sel +: 4];
        end
      end
      if (reg_wr && buf_ctl) begin
        prio[2*wr_buf +: 2] <= reg_wdata[`CTS_CTL_PRIO_HI:`CTS_CTL_PRIO_LO];
      end
      if (mem_wr && wr_byte == `CTS_LEN_BYTE) begin
        len_code[4*wr_buf +: 4] <= reg_wdata[3:0];
      end
      if (reg_wr && reg_addr == `CTS_PIN_CTRL && config_mode) begin
        pin_mode <= reg_wdata[`CTS_PIN_MODE_LO +: 3];
      end
      if (reg_wr && reg_addr == `CTS_CTRL_CTRL) begin
        abort_all   <= reg_wdata[`CTS_CC_ABORT_ALL];
        config_mode <= reg_wdata[`CTS_CC_CONFIG];
      end
      if (reg_wr && reg_addr == `CTS_INT_ENABLE) begin
        int_en <= reg_wdata[3:0];
      end
    end
  end

endmodule // cts_scheduler

`default_nettype wire

// *** dv/cts_scheduler_props.sv ***
// assertions on the transmit scheduler ports
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.vh"
module cts_sched_props (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       bus_idle,
  input wire logic       eng_tx_valid,
  input wire logic [1:0] eng_tx_buf,
  input wire logic [3:0] eng_data_count,
  input wire logic       eng_start,
  input wire logic       eng_done,
  input wire logic       eng_error,
  input wire logic       irq
);
  wire ctrl_addr = reg_addr == `CTS_TXB0_CTRL || reg_addr == `CTS_TXB1_CTRL
                   || reg_addr == `CTS_TXB2_CTRL;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // steps
  sequence s_begin;
    eng_tx_valid && eng_start;
  endsequence
  sequence s_ctrl_rd;
    reg_rd && ctrl_addr ##1 !reg_rd;
  endsequence
  sequence s_pin_rd;
    reg_rd && reg_addr == `CTS_PIN_CTRL ##1 !reg_rd;
  endsequence
  // ==========================================================================
  // checks
  offer_has_buf_a: assert property (eng_tx_valid |-> eng_tx_buf != 2'h3)
    else $error("offer without buffer");
  count_cap_a: assert property (eng_tx_valid |-> eng_data_count <= 4'h8)
    else $error("data count above eight");
  offer_after_idle_a: assert property ($rose(eng_tx_valid) |-> $past(bus_idle))
    else $error("offer without free bus");
  start_ends_offer_a: assert property (s_begin |=> !eng_tx_valid)
    else $error("offer kept after start");
  send_buf_held_a: assert property (s_begin |=> $stable(eng_tx_buf))
    else $error("buffer changed after start");
  irq_cause_a: assert property ($rose(irq) |-> $past(eng_done)
    || $past(eng_error) || $past(eng_done, 2) || $past(eng_error, 2) || $past(reg_wr)
    || $past(reg_wr, 2))
    else $error("interrupt without cause");
  ctrl_zero_bits_a: assert property (s_ctrl_rd |=> !reg_rdata[7] && !reg_rdata[2])
    else $error("control spare bits set");
  pin_zero_bits_a: assert property (s_pin_rd |=> reg_rdata[7:6] == 2'h0)
    else $error("pin control spare bits set");
  reset_state_a: assert property (disable iff (1'b0) rst
    |-> eng_tx_buf == 2'h3 && !eng_tx_valid && !irq)
    else $error("outputs not idle in reset");
endmodule // cts_sched_props

bind cts_scheduler cts_sched_props u_props (
  .core_clk(core_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .bus_idle(bus_idle),
  .eng_tx_valid(eng_tx_valid),
  .eng_tx_buf(eng_tx_buf),
  .eng_data_count(eng_data_count),
  .eng_start(eng_start),
  .eng_done(eng_done),
  .eng_error(eng_error),
  .irq(irq)
);
`default_nettype wire

// *** dv/cts_engine_model.sv ***
// protocol engine stand-in: starts offered buffers, reports an outcome
`timescale 1ns/1ps
`default_nettype none
module cts_engine_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       eng_tx_valid,
  input  wire logic [1:0] eng_tx_buf,
  input  wire logic [1:0] outcome,
  input  wire logic       hold_bus,
  output logic            bus_idle,
  output logic            eng_start,
  output logic            eng_done,
  output logic            eng_error,
  output logic            eng_lost_arb,
  output logic [1:0]      sent_buf,
  output logic            sent_stb
);
  logic       busy;
  logic [3:0] cnt;
  // ==========================================================================
  // bus free only between frames
  assign bus_idle = !busy && !hold_bus;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      eng_start <= 1'b0;
      eng_done <= 1'b0;
      eng_error <= 1'b0;
      eng_lost_arb <= 1'b0;
      sent_buf <= 2'h0;
      sent_stb <= 1'b0;
    end else begin
      eng_start <= 1'b0;
      eng_done <= 1'b0;
      eng_error <= 1'b0;
      eng_lost_arb <= 1'b0;
      sent_stb <= 1'b0;
      if (busy) begin
        cnt <= cnt + 4'h1;
        if (cnt == 4'h7) begin
          busy <= 1'b0;
          sent_stb <= 1'b1;
          sent_buf <= eng_tx_buf;
          eng_done <= outcome == 2'h0;
          eng_error <= outcome == 2'h1;
          eng_lost_arb <= outcome == 2'h2;
        end
      end else if (eng_tx_valid && !hold_bus) begin
        busy <= 1'b1;
        cnt <= 4'h0;
        eng_start <= 1'b1;
      end
    end
  end
endmodule // cts_engine_model
`default_nettype wire

// *** dv/cts_scheduler_tb.sv ***
// self-checking bench for the transmit scheduler
`timescale 1ns/1ps
`default_nettype none
`include "cts_regs.vh"
module cts_scheduler_tb;
  logic       core_clk, rst, reg_wr, reg_rd, hold_bus, sent_stb, bus_idle, irq;
  logic       eng_tx_valid, eng_start, eng_done, eng_error, eng_lost_arb, eng_rd_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, eng_rd_data;
  logic [3:0] eng_data_count, eng_rd_byte;
  logic [2:0] request_pin_n;
  logic [1:0] outcome, eng_tx_buf, sent_buf, b;
  int         num_errors, n_checks, i, k;
  // priorities p0 [1:0], p1 [3:2], p2 [5:4], first sent [7:6]
  logic [7:0] rows [6] = '{8'hA4, 8'h03, 8'h45, 8'hAA, 8'hBF, 8'h5C};

  cts_scheduler u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .request_pin_n(request_pin_n), .bus_idle(bus_idle), .eng_tx_valid(eng_tx_valid),
    .eng_tx_buf(eng_tx_buf), .eng_data_count(eng_data_count), .eng_start(eng_start),
    .eng_done(eng_done), .eng_error(eng_error), .eng_lost_arb(eng_lost_arb),
    .eng_rd_en(eng_rd_en), .eng_rd_byte(eng_rd_byte), .eng_rd_data(eng_rd_data),
    .irq(irq));
  cts_engine_model u_eng (.core_clk(core_clk), .rst(rst), .eng_tx_valid(eng_tx_valid),
    .eng_tx_buf(eng_tx_buf), .outcome(outcome), .hold_bus(hold_bus),
    .bus_idle(bus_idle), .eng_start(eng_start), .eng_done(eng_done),
    .eng_error(eng_error), .eng_lost_arb(eng_lost_arb), .sent_buf(sent_buf),
    .sent_stb(sent_stb));

  // ==========================================================================
  // tasks
  task automatic report_and_stop; begin
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s); begin
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  end endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v); begin
    @(negedge core_clk); reg_addr = a; reg_wdata = v; reg_wr = 1;
    @(negedge core_clk); reg_wr = 0;
  end endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v); begin
    @(negedge core_clk); reg_addr = a; reg_rd = 1;
    @(negedge core_clk); reg_rd = 0;
    @(negedge core_clk); v = reg_rdata;
  end endtask
  task automatic wait_sent(output logic [1:0] s); int n; begin
    for (n = 0; n < 60 && sent_stb !== 1'b1; n++) @(negedge core_clk);
    chk("sent_stb", 8'h01, {7'h0, sent_stb});
    s = sent_buf;
    chk("data count", (s == 2'h1) ? 8'h05 : 8'h08, {4'h0, eng_data_count});
    @(negedge core_clk);
  end endtask

  // ==========================================================================
  // clock, watchdog, sequence
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000 num_errors++;
    report_and_stop;
  end
  initial begin
    rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; request_pin_n = 3'h7;
    hold_bus = 1; outcome = 0; num_errors = 0; n_checks = 0;
    eng_rd_en = 0; eng_rd_byte = 4'h0;
    repeat (2) @(negedge core_clk);
    rst = 0;
    wr(`CTS_PIN_CTRL, 8'h07);
    wr(`CTS_INT_ENABLE, 8'h0F);
    for (k = 0; k < 3; k++) wr(8'(8'h35 + 16 * k), 8'h0A);
    wr(8'h45, 8'h05);
    wr(`CTS_CTRL_CTRL, 8'h00);
    for (i = 0; i < 6; i++) begin
      hold_bus = 1;
      for (k = 0; k < 3; k++) wr(8'(8'h30 + 16 * k), {6'h02, rows[i][2*k +: 2]});
      hold_bus = 0;
      wait_sent(b); chk("first buf", {6'h0, rows[i][7:6]}, {6'h0, b});
      wait_sent(b);
      wait_sent(b);
    end
    hold_bus = 1;
    rd(`CTS_TXB0_CTRL, d); chk("done ctl", 8'h00, d);
    rd(`CTS_INT_FLAG, d); chk("done flags", 8'h07, d & 8'h0F);
    chk("irq set", 8'h01, {7'h0, irq});
    wr(`CTS_INT_FLAG, 8'h00); rd(`CTS_INT_FLAG, d); chk("irq clr", 8'h00, {7'h0, irq});
    outcome = 1; wr(`CTS_TXB0_CTRL, 8'h0B); hold_bus = 0;
    wait_sent(b); hold_bus = 1;
    rd(`CTS_TXB0_CTRL, d); chk("error ctl", 8'h1B, d);
    rd(`CTS_INT_FLAG, d); chk("merr flag", 8'h08, d & 8'h08);
    outcome = 2; hold_bus = 0; wait_sent(b); hold_bus = 1;
    rd(`CTS_TXB0_CTRL, d); chk("lost ctl", 8'h28, d & 8'h28);
    outcome = 0; hold_bus = 0; wait_sent(b); hold_bus = 1;
    wr(`CTS_TXB0_CTRL, 8'h0B); rd(`CTS_TXB0_CTRL, d); chk("req clr", 8'h0B, d);
    wr(8'h35, 8'h03); rd(8'h35, d); chk("load refused", 8'h0A, d);
    wr(`CTS_TXB0_CTRL, 8'h03); rd(`CTS_TXB0_CTRL, d); chk("abort one", 8'h03, d);
    wr(`CTS_TXB0_CTRL, 8'h0B); wr(`CTS_CTRL_CTRL, 8'h10);
    rd(`CTS_TXB0_CTRL, d); chk("abort all", 8'h43, d);
    wr(`CTS_TXB2_CTRL, 8'h0A); hold_bus = 0;
    repeat (6) @(negedge core_clk);
    rd(`CTS_TXB2_CTRL, d); chk("abort held", 8'h42, d);
    hold_bus = 1; wr(`CTS_CTRL_CTRL, 8'h00);
    wr(`CTS_PIN_CTRL, 8'h00); rd(`CTS_PIN_CTRL, d); chk("pin ctl", 8'h07, d);
    request_pin_n = 3'h3;
    repeat (3) @(negedge core_clk);
    rd(`CTS_TXB2_CTRL, d); chk("pin req", 8'h0A, d);
    request_pin_n = 3'h7; hold_bus = 0;
    wait_sent(b); chk("pin buf", 8'h02, {6'h0, b});
    eng_rd_en = 1; eng_rd_byte = 4'h5;
    @(negedge core_clk); eng_rd_en = 0;
    chk("engine read", 8'h0A, eng_rd_data);
    rst = 1;
    repeat (2) @(negedge core_clk);
    rst = 0;
    rd(`CTS_CTRL_CTRL, d); chk("rst cc", 8'h80, d);
    rd(`CTS_PIN_CTRL, d); chk("rst pin", 8'h38, d);
    rd(`CTS_TXB1_CTRL, d); chk("rst ctl", 8'h00, d);
    report_and_stop;
  end
endmodule // cts_scheduler_tb
`default_nettype wire
